/* mtcs_cfg.svh */
// Contract
// RL1: single store: two N cycles, prefetch pc+2i then sized write of source register.
// RL2: store write cycle drives privilege 0 when user translation forced, else mode value.
// RL3: store: cycle 1 computes address, cycle 2 writes memory and updates base.
// RL4: load multiple: cycle 1 address plus prefetch, cycle 2 first read and base update.
// RL5: each further word writes previous word back while reading next; base kept.
// RL6: last load multiple cycle is internal, moves last word to its register.
// RL7: after data abort run to end, block register writes, final cycle restores base.
// RL8: program counter is always loaded last, so any abort leaves it unchanged.
// RL9: loading pc discards pipeline: N cycle at pc+3i, then S fetches pc' and pc'+i.
// RL10: load multiple reads are words; first S when several; single read is internal.
// RL11: no pc-writing load multiple in compressed state except stack pull with pc.
// RL12: store multiple follows load multiple without final internal cycle.
// RL13: store multiple writes words; middle ones sequential, last nonsequential.
// RL14: swap: N prefetch pc+8, N read base, internal-typed write, S prefetch pc+12.
// RL15: swap writes value read in cycle 2 to destination in cycle 4.
// RL16: swap size is byte or word, same for read and write.
// RL17: aborted swap read or write leaves destination register unchanged.
// RL18: atomic_hold high in swap read and write cycles, low in first and fourth.
// RL19: no data swap is executed in compressed state.
// RL20: size codes mean byte, halfword and word per bus encoding.
// RL21: memory controller blocks other masters while atomic_hold is high.
// RL22: data_not_opcode low on prefetch cycles, high on data and internal cycles; code drives it high on the pc+3i and swap pc+12 fetches.
`ifndef MTCS_CFG_SVH
`define MTCS_CFG_SVH
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
`define CT_IDLE 2'h0
`define CT_INT 2'h1
`define CT_NSEQ 2'h2
`define CT_SEQ 2'h3
`define OP_STR 3'h0
`define OP_LDM 3'h1
`define OP_STM 3'h2
`define OP_SWP 3'h3
`define OP_POP 3'h4
`define PC_REG 4'hF
`endif

/* mtcs_pkg.sv */
package mtcs_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic write;
    logic [1:0] cycle_type;
    logic data_not_opcode;
    logic privileged_access;
    logic atomic_hold;
    logic [31:0] wdata;
  } bus_t;
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [31:0] data;
  } reg_wr_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_STR2, ST_MULT, ST_LAST, ST_PCN, ST_PC1, ST_PC2, ST_SWP
  } state_t;
  typedef struct packed {
    state_t st;
    logic [2:0] op;
    logic [1:0] step;
    logic [15:0] list;
    logic [3:0] prev;
    logic have_prev;
    logic aborted;
    logic [31:0] pc;
    logic [31:0] da;
    logic [31:0] base_new;
    logic [3:0] base_idx;
    logic [31:0] rdata;
    logic [3:0] dest;
    logic wide;
    logic [31:0] newpc;
    logic busy;
    bus_t bus;
    reg_wr_t rw;
  } seq_t;
endpackage : mtcs_pkg

/* mtcs_seq.sv */
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "mtcs_cfg.svh"
module memory_transfer_cycle_sequencer (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] opcode,
  input wire logic compressed,
  input wire logic [31:0] pc,
  input wire logic [31:0] data_addr,
  input wire logic [31:0] base_new,
  input wire logic [3:0] base_idx,
  input wire logic [15:0] reg_list,
  input wire logic [3:0] dest_idx,
  input wire logic [31:0] src_data,
  input wire logic [1:0] xfer_size,
  input wire logic store_user_translate,
  input wire logic mode_priv,
  input wire logic [31:0] rdata,
  input wire logic abort,
  output mtcs_pkg::bus_t bus,
  output mtcs_pkg::reg_wr_t reg_wr,
  output logic [3:0] src_idx,
  output logic busy,
  output logic pipe_flush
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_b;
  logic rst_s2_b;
  mtcs_pkg::seq_t s_q;
  mtcs_pkg::seq_t s_d;
  logic [3:0] src_q;
  logic [3:0] src_d;
  logic flush_q;
  logic flush_d;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_b <= 1'b0;
      rst_s2_b <= 1'b0;
    end
    else
    begin
      rst_s1_b <= 1'b1;
      rst_s2_b <= rst_s1_b;
    end
  end

  // lowest set bit first; pc is bit 15 so it always comes last
  function automatic logic [3:0] first_reg(input logic [15:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (l[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_reg

  function automatic logic [4:0] count_regs(input logic [15:0] l);
    logic [4:0] c;
    c = 5'h0;
    for (int i = 0; i < 16; i++)
    begin
      c = c + {4'h0, l[i]};
    end
    return c;
  endfunction : count_regs

  function automatic mtcs_pkg::bus_t fetch(input logic [31:0] a, input logic [1:0] ct, input logic w, input logic p);
    mtcs_pkg::bus_t b;
    b = '0;
    b.addr = a;
    b.size = w ? `SZ_WORD : `SZ_HALF;
    b.cycle_type = ct;
    b.data_not_opcode = 1'b0; // RL22
    b.privileged_access = p;
    return b;
  endfunction : fetch

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] step_i;
  logic [31:0] ilen;
  logic [15:0] rest;
  logic [3:0] nxt;

  always_comb
  begin
    s_d = s_q;
    src_d = src_q;
    flush_d = 1'b0;
    s_d.rw = '0;
    ilen = s_q.wide ? 32'h4 : 32'h2;
    step_i = first_reg(s_q.list);
    rest = s_q.list & ~(16'h1 << step_i);
    nxt = first_reg(rest);
    unique case (s_q.st)
      mtcs_pkg::ST_IDLE:
      begin
        s_d.bus = '0;
        s_d.busy = 1'b0;
        // illegal opcodes in compressed state are refused quietly
        if (start && !(compressed && (opcode == `OP_SWP)) && // RL19
            !(compressed && opcode == `OP_LDM && reg_list[15])) // RL11
        begin
          s_d.op = opcode;
          s_d.wide = !compressed;
          s_d.pc = pc;
          s_d.da = data_addr; // RL3 RL4
          s_d.base_new = base_new;
          s_d.base_idx = base_idx;
          s_d.list = reg_list;
          s_d.dest = dest_idx;
          s_d.aborted = 1'b0;
          s_d.have_prev = 1'b0;
          s_d.busy = 1'b1;
          if (opcode == `OP_POP)
          begin
            s_d.op = `OP_LDM; // RL11
          end
          if (opcode == `OP_SWP)
          begin
            s_d.bus = fetch(pc + 32'h8, `CT_NSEQ, 1'b1, mode_priv); // RL14
            s_d.step = 2'h0;
            s_d.st = mtcs_pkg::ST_SWP;
          end
          else
          begin
            s_d.bus = fetch(pc + (compressed ? 32'h4 : 32'h8), `CT_NSEQ, !compressed, mode_priv); // RL1 RL4
            s_d.st = (opcode == `OP_STR) ? mtcs_pkg::ST_STR2 : mtcs_pkg::ST_MULT;
            src_d = (opcode == `OP_STR) ? dest_idx : first_reg(reg_list);
          end
        end
      end
      mtcs_pkg::ST_STR2:
      begin
        s_d.bus = '0;
        s_d.bus.addr = s_q.da;
        s_d.bus.size = xfer_size; // RL20
        s_d.bus.write = 1'b1;
        s_d.bus.cycle_type = `CT_NSEQ; // RL1
        s_d.bus.data_not_opcode = 1'b1; // RL22
        s_d.bus.privileged_access = store_user_translate ? 1'b0 : mode_priv; // RL2
        s_d.bus.wdata = src_data;
        s_d.rw = '{valid: 1'b1, idx: s_q.base_idx, data: s_q.base_new}; // RL3
        s_d.st = mtcs_pkg::ST_LAST;
      end
      mtcs_pkg::ST_MULT:
      begin
        // one data cycle per listed register
        s_d.bus = '0;
        s_d.bus.addr = s_q.da;
        s_d.bus.size = `SZ_WORD; // RL10 RL13
        s_d.bus.data_not_opcode = 1'b1;
        s_d.bus.privileged_access = mode_priv;
        if (s_q.op == `OP_STM)
        begin
          s_d.bus.write = 1'b1;
          s_d.bus.wdata = src_data;
          s_d.bus.cycle_type = (rest == 16'h0) ? `CT_NSEQ : `CT_SEQ; // RL13
        end
        else
        begin
          s_d.bus.cycle_type = (rest == 16'h0) ? `CT_INT : `CT_SEQ; // RL10
        end
        if (!s_q.have_prev)
        begin
          s_d.rw = '{valid: 1'b1, idx: s_q.base_idx, data: s_q.base_new}; // RL4 RL12
        end
        s_d.prev = step_i;
        s_d.have_prev = (s_q.op == `OP_LDM);
        s_d.da = s_q.da + 32'h4;
        s_d.list = rest;
        src_d = nxt;
        s_d.st = (rest == 16'h0) ? mtcs_pkg::ST_LAST : mtcs_pkg::ST_MULT;
      end
      mtcs_pkg::ST_LAST:
      begin
        // final internal cycle; store forms end after their last write, so the bus idles
        s_d.bus = fetch(s_q.pc + ilen + ilen + ilen, `CT_SEQ, s_q.wide, mode_priv);
        s_d.bus.data_not_opcode = 1'b1;
        s_d.st = mtcs_pkg::ST_IDLE;
        s_d.busy = 1'b0;
        if (s_q.op != `OP_LDM)
        begin
          s_d.bus = '0; // RL1 RL12
        end
        if (s_q.op == `OP_LDM)
        begin
          s_d.bus.cycle_type = `CT_SEQ; // RL10
          // the pc word itself may abort, so this cycle's answer counts too
          if (s_q.aborted || abort)
          begin
            s_d.rw = '{valid: 1'b1, idx: s_q.base_idx, data: s_q.base_new}; // RL7
          end
          else if (s_q.prev == `PC_REG)
          begin
            s_d.newpc = rdata;
            s_d.rw = '{valid: 1'b1, idx: `PC_REG, data: rdata}; // RL8
            s_d.bus.cycle_type = `CT_NSEQ; // RL9
            s_d.st = mtcs_pkg::ST_PC1;
            s_d.busy = 1'b1;
            flush_d = 1'b1; // RL9
          end
          else
          begin
            s_d.rw = '{valid: 1'b1, idx: s_q.prev, data: rdata}; // RL6
          end
        end
      end
      mtcs_pkg::ST_PC1:
      begin
        s_d.bus = fetch(s_q.newpc, `CT_SEQ, s_q.wide, mode_priv); // RL9
        s_d.st = mtcs_pkg::ST_PC2;
      end
      mtcs_pkg::ST_PC2:
      begin
        s_d.bus = fetch(s_q.newpc + ilen, `CT_SEQ, s_q.wide, mode_priv); // RL9
        s_d.st = mtcs_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
      mtcs_pkg::ST_SWP:
      begin
        s_d.step = s_q.step + 2'h1;
        s_d.bus = '0;
        s_d.bus.addr = s_q.da;
        s_d.bus.size = (xfer_size == `SZ_BYTE) ? `SZ_BYTE : `SZ_WORD; // RL16
        s_d.bus.data_not_opcode = 1'b1;
        s_d.bus.privileged_access = mode_priv;
        s_d.bus.atomic_hold = 1'b1; // RL18 RL21
        if (s_q.step == 2'h0)
        begin
          s_d.bus.cycle_type = `CT_NSEQ; // RL14
        end
        else if (s_q.step == 2'h1)
        begin
          s_d.rdata = rdata;
          s_d.bus.write = 1'b1;
          s_d.bus.wdata = src_data;
          s_d.bus.cycle_type = `CT_INT; // RL14
        end
        else
        begin
          s_d.bus = fetch(s_q.pc + 32'hC, `CT_SEQ, 1'b1, mode_priv); // RL14 RL18
          s_d.bus.data_not_opcode = 1'b1;
          if (!(s_q.aborted || abort))
          begin
            s_d.rw = '{valid: 1'b1, idx: s_q.dest, data: s_q.rdata}; // RL15 RL17
          end
          s_d.st = mtcs_pkg::ST_IDLE;
          s_d.busy = 1'b0;
        end
      end
      default:
      begin
        s_d.st = mtcs_pkg::ST_IDLE;
      end
    endcase
    // loaded words land one cycle late; abort blocks every later loaded-word write
    if (s_q.st == mtcs_pkg::ST_MULT && s_q.have_prev && !s_q.aborted && !abort)
    begin
      s_d.rw = '{valid: 1'b1, idx: s_q.prev, data: rdata}; // RL5
    end
    if (abort && s_q.bus.data_not_opcode && s_q.st != mtcs_pkg::ST_IDLE)
    begin
      s_d.aborted = 1'b1; // RL7 RL17
    end
  end

  always_ff @(posedge mclk or negedge rst_s2_b)
  begin
    if (!rst_s2_b)
    begin
      s_q <= '0;
      src_q <= 4'h0;
      flush_q <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
      src_q <= src_d;
      flush_q <= flush_d;
    end
  end

  assign bus = s_q.bus;
  assign reg_wr = s_q.rw;
  assign src_idx = src_q;
  assign busy = s_q.busy;
  assign pipe_flush = flush_q;
endmodule : memory_transfer_cycle_sequencer

/* mtcs_mem_model.sv */
`timescale 1ns/1ns
module mtcs_mem_model (
  input wire logic mclk,
  input wire mtcs_pkg::bus_t bus,
  input wire logic [31:0] fail_addr,
  output logic [31:0] rdata,
  output logic abort
);
  logic others_held;
  // no second master here; the lock is only mirrored on others_held, which nothing reads
  assign others_held = bus.atomic_hold;
  // answer stands in the same cycle as its address, where the sequencer samples it
  // write cycles show inverted data rather than a plausible stale read
  assign rdata = bus.write ? ~(bus.addr ^ 32'h5A5A_0000) : (bus.addr ^ 32'h5A5A_0000);
  assign abort = bus.data_not_opcode && (bus.addr == fail_addr);
endmodule : mtcs_mem_model

/* mtcs_seq_assertions.sv */
`timescale 1ns/1ns
`include "mtcs_cfg.svh"
module mtcs_seq_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] opcode,
  input wire logic compressed,
  input wire logic [31:0] pc,
  input wire logic [15:0] reg_list,
  input wire mtcs_pkg::bus_t bus,
  input wire logic busy,
  input wire logic pipe_flush
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  chk_first_fetch: assert property ($rose(busy) |-> bus.cycle_type == `CT_NSEQ && !bus.write
    && !bus.data_not_opcode) else $error("first cycle not an N prefetch");
  chk_fetch_addr: assert property ($rose(busy) |-> bus.addr == $past(pc) + ($past(compressed) ? 32'h4 : 32'h8))
    else $error("prefetch address wrong");
  chk_write_data: assert property (bus.write |-> bus.data_not_opcode) else $error("write marked as opcode");
  chk_lock_seq: assert property ($rose(bus.atomic_hold) |-> !bus.write ##1 bus.atomic_hold && bus.write
    && bus.cycle_type == `CT_INT ##1 !bus.atomic_hold && bus.cycle_type == `CT_SEQ) else $error("swap lock order");
  chk_lock_start: assert property ($rose(bus.atomic_hold) |-> bus.cycle_type == `CT_NSEQ && $past(busy))
    else $error("swap read not N");
  chk_lock_same: assert property (bus.atomic_hold && bus.write |-> bus.addr == $past(bus.addr)
    && bus.size == $past(bus.size)) else $error("swap write differs from read");
  chk_lock_size: assert property (bus.atomic_hold |-> bus.size != `SZ_HALF) else $error("swap halfword");
  chk_no_swap_comp: assert property (start && !busy && compressed && opcode == `OP_SWP |=> !busy)
    else $error("compressed swap ran");
  chk_no_ldm_pc: assert property (start && !busy && compressed && opcode == `OP_LDM && reg_list[15] |=> !busy)
    else $error("compressed pc load ran");
  cover property ($rose(bus.atomic_hold));
  cover property ($rose(pipe_flush));
  cover property (bus.write && bus.cycle_type == `CT_SEQ);
endmodule : mtcs_seq_chk
bind memory_transfer_cycle_sequencer mtcs_seq_chk chk (.mclk(mclk), .rst_b(rst_b), .start(start), .opcode(opcode),
  .compressed(compressed), .pc(pc), .reg_list(reg_list), .bus(bus), .busy(busy), .pipe_flush(pipe_flush));

/* tb.sv */
`timescale 1ns/1ns
`include "mtcs_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module tb;
  localparam logic [31:0] K = 32'h5A5A_0000;
  logic mclk = 0, rst_b = 0, start = 0, compressed = 0, sut = 0, mode_priv = 1, abort, busy, pipe_flush, bz, fl;
  logic [2:0] opcode = 0;
  logic [31:0] pc = 32'h100, data_addr = 32'h300, base_new = 32'h0BA5_E000, src_data, rdata, fail_addr = '1;
  logic [3:0] base_idx = 4'hD, dest_idx = 4'h6, src_idx;
  logic [15:0] reg_list = 0;
  logic [1:0] xfer_size = 0;
  mtcs_pkg::bus_t bus;
  mtcs_pkg::bus_t cyc [16];
  mtcs_pkg::reg_wr_t reg_wr;
  mtcs_pkg::reg_wr_t wq [$];
  int n_checks = 0, bad_count = 0;
  assign src_data = {28'hC00_0000, src_idx};
  memory_transfer_cycle_sequencer dut (.mclk(mclk), .rst_b(rst_b), .start(start), .opcode(opcode),
    .compressed(compressed), .pc(pc), .data_addr(data_addr), .base_new(base_new), .base_idx(base_idx),
    .reg_list(reg_list), .dest_idx(dest_idx), .src_data(src_data), .xfer_size(xfer_size),
    .store_user_translate(sut), .mode_priv(mode_priv), .rdata(rdata), .abort(abort), .bus(bus),
    .reg_wr(reg_wr), .src_idx(src_idx), .busy(busy), .pipe_flush(pipe_flush));
  mtcs_mem_model mem (.mclk(mclk), .bus(bus), .fail_addr(fail_addr), .rdata(rdata), .abort(abort));
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [3:0] i, input logic [31:0] d);
    hit = 0;
    foreach (wq[j]) if (wq[j].idx === i && wq[j].data === d) hit = 1;
  endfunction : hit
  // fixed window outlasts every sequence, so the next start always finds busy low
  task automatic run(input logic [2:0] op, input logic [15:0] l, input logic c);
    opcode <= op;
    reg_list <= l;
    compressed <= c;
    start <= 1;
    @(posedge mclk);
    start <= 0;
    wq.delete();
    fl = 0;
    bz = 0;
    for (int k = 0; k < 14; k++)
    begin
      @(negedge mclk);
      cyc[k] = bus;
      if (reg_wr.valid === 1'b1) wq.push_back(reg_wr);
      fl |= pipe_flush === 1'b1;
      bz |= busy !== 1'b0;
      @(posedge mclk);
    end
  endtask : run
  task automatic cb(input int k, input logic [31:0] a, input logic [1:0] t, input logic w, input logic d);
    `CHK(cyc[k].addr, a)
    `CHK(cyc[k].cycle_type, t)
    `CHK(cyc[k].write, w)
    `CHK(cyc[k].data_not_opcode, d)
  endtask : cb
  ////////////////////////////////////////////////////////////////
  task automatic s_str;
    for (int s = 0; s < 3; s++)
    begin
      data_addr <= 32'h200;
      xfer_size <= 2'(s);
      sut <= (s == 0);
      run(`OP_STR, 16'h0, 0);
      cb(0, 32'h108, `CT_NSEQ, 0, 0);
      cb(1, 32'h200, `CT_NSEQ, 1, 1);
      `CHK(cyc[1].size, 2'(s))
      `CHK(cyc[1].wdata, 32'hC000_0006)
      `CHK(cyc[1].privileged_access, s != 0)
      `CHK(cyc[2].cycle_type, `CT_IDLE)
      `CHK(hit(4'hD, base_new), 1'b1)
    end
  endtask : s_str
  task automatic s_ldm;
    data_addr <= 32'h300;
    run(`OP_LDM, 16'h0016, 0);
    cb(0, 32'h108, `CT_NSEQ, 0, 0);
    cb(1, 32'h300, `CT_SEQ, 0, 1);
    cb(2, 32'h304, `CT_SEQ, 0, 1);
    cb(3, 32'h308, `CT_INT, 0, 1);
    cb(4, 32'h10C, `CT_SEQ, 0, 1);
    `CHK(cyc[2].size, `SZ_WORD)
    `CHK({hit(4'h1, 32'h300 ^ K), hit(4'h2, 32'h304 ^ K), hit(4'h4, 32'h308 ^ K)}, 3'b111)
    `CHK(hit(4'hD, base_new), 1'b1)
    run(`OP_LDM, 16'h0001, 0);
    cb(1, 32'h300, `CT_INT, 0, 1);
    cb(2, 32'h10C, `CT_SEQ, 0, 1);
    run(`OP_LDM, 16'h8001, 0);
    cb(2, 32'h304, `CT_INT, 0, 1);
    cb(3, 32'h10C, `CT_NSEQ, 0, 1);
    cb(4, 32'h304 ^ K, `CT_SEQ, 0, 0);
    cb(5, 32'h308 ^ K, `CT_SEQ, 0, 0);
    `CHK(fl, 1'b1)
    `CHK(wq[$].idx, `PC_REG)
    run(`OP_POP, 16'h8001, 1);
    cb(0, 32'h104, `CT_NSEQ, 0, 0);
    cb(3, 32'h106, `CT_NSEQ, 0, 1);
    cb(5, 32'h306 ^ K, `CT_SEQ, 0, 0);
  endtask : s_ldm
  task automatic s_abort;
    fail_addr <= 32'h304;
    run(`OP_LDM, 16'h8003, 0);
    cb(4, 32'h10C, `CT_SEQ, 0, 1);
    `CHK({hit(4'h1, 32'h304 ^ K), hit(`PC_REG, 32'h308 ^ K), fl}, 3'b000)
    `CHK(wq[$].data, base_new)
    fail_addr <= 32'h308;
    run(`OP_LDM, 16'h8003, 0);
    `CHK({hit(4'h1, 32'h304 ^ K), hit(`PC_REG, 32'h308 ^ K), fl}, 3'b100)
    `CHK(wq[$].data, base_new)
    fail_addr <= 32'h400;
    data_addr <= 32'h400;
    run(`OP_SWP, 16'h0, 0);
    `CHK(hit(4'h6, 32'h400 ^ K), 1'b0)
    fail_addr <= '1;
  endtask : s_abort
  task automatic s_stm;
    data_addr <= 32'h300;
    run(`OP_STM, 16'h002C, 0);
    cb(1, 32'h300, `CT_SEQ, 1, 1);
    cb(2, 32'h304, `CT_SEQ, 1, 1);
    cb(3, 32'h308, `CT_NSEQ, 1, 1);
    `CHK({cyc[1].wdata, cyc[3].wdata, cyc[3].size}, {32'hC000_0002, 32'hC000_0005, `SZ_WORD})
    `CHK(cyc[4].cycle_type, `CT_IDLE)
    run(`OP_STM, 16'h0010, 0);
    cb(1, 32'h300, `CT_NSEQ, 1, 1);
    `CHK(cyc[2].cycle_type, `CT_IDLE)
  endtask : s_stm
  task automatic s_swp;
    for (int s = 0; s < 3; s += 2)
    begin
      data_addr <= 32'h400;
      xfer_size <= 2'(s);
      run(`OP_SWP, 16'h0, 0);
      cb(0, 32'h108, `CT_NSEQ, 0, 0);
      cb(1, 32'h400, `CT_NSEQ, 0, 1);
      cb(2, 32'h400, `CT_INT, 1, 1);
      cb(3, 32'h10C, `CT_SEQ, 0, 1);
      `CHK({cyc[1].size, cyc[2].size}, {2'(s), 2'(s)})
      `CHK({cyc[0].atomic_hold, cyc[1].atomic_hold, cyc[2].atomic_hold, cyc[3].atomic_hold}, 4'b0110)
      `CHK(hit(4'h6, 32'h400 ^ K), 1'b1)
      `CHK(bz, 1'b1)
    end
    run(`OP_SWP, 16'h0, 1);
    `CHK(bz, 1'b0)
    run(`OP_LDM, 16'h8001, 1);
    `CHK(bz, 1'b0)
  endtask : s_swp
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_b <= 1;
    repeat (3) @(posedge mclk);
    s_str;
    s_ldm;
    s_abort;
    s_stm;
    s_swp;
    end_of_test;
  end
  initial
  begin
    #(400 * 50);
    bad_count++;
    end_of_test;
  end
endmodule : tb
